/* File: include/ssi_link_if.sv */
// signal bundle between the sequencer core and its link-clock slave
`timescale 1ns/1ps
interface ssi_link_if;
  import ssi_pkg::*;
  logic [SIZE_W-1:0] wordSizeM1;
  logic cmdResp;
  logic clockPolarity;
  logic clockPhase;
  logic [WORD_W-1:0] txWord;
  logic [WORD_W-1:0] rxWord;
  logic doneToggle;
  logic slaveBit;

  modport core (
    output wordSizeM1, cmdResp, clockPolarity, clockPhase, txWord,
    input rxWord, doneToggle, slaveBit
  );
  modport link (
    input wordSizeM1, cmdResp, clockPolarity, clockPhase, txWord,
    output rxWord, doneToggle, slaveBit
  );
endinterface

/* File: include/ssi_pkg.sv */
// shared constants and types for the serial frame sequencer
package ssi_pkg;
  localparam int WORD_W = 16;
  localparam int SIZE_W = 4;
  localparam int SYNC_STAGES = 2;
  // word length is held as length minus one
  localparam logic [SIZE_W-1:0] MIN_SIZE_M1 = 4'h3;
  localparam logic [SIZE_W-1:0] TOP_BIT = 4'hF;
  // command/response control word and decode wait, in bits minus one
  localparam logic [SIZE_W-1:0] CTRL_SIZE_M1 = 4'h7;
  localparam logic [SIZE_W-1:0] WAIT_SIZE_M1 = 4'h0;
  localparam logic [WORD_W-1:0] ALL_ONES = 16'hFFFF;
  localparam logic [WORD_W-1:0] NO_BITS = 16'h0000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_START = 2'b01,
    ST_SHIFT = 2'b10,
    ST_TAIL = 2'b11
  } seq_state_e;

  typedef enum logic [1:0] {
    CR_CTRL = 2'b00,
    CR_WAIT = 2'b01,
    CR_REPLY = 2'b10
  } cr_phase_e;
endpackage

/* File: logic/ssi_frame_sequencer.sv */
// serial frame sequencer for spi and command/response framing
// Summary of operation
// [RULE1]: words go msb first, 4 to 16 bits
// [RULE2]: polarity picks idle level, phase picks capture edge
// [RULE3]: mode 1: select low, data with first rise
// [RULE4]: mode 1: sample falling, change rising
// [RULE5]: select rises one period after last capture
// [RULE6]: phase 1 bursts keep select low between words
// [RULE7]: polarity 1 idle: clock high, select high, data low
// [RULE8]: master drives clock pad, slave leaves it undriven
// [RULE9]: mode 2: slave data, master data, clock falls
// [RULE10]: mode 2: sample falling, change rising
// [RULE11]: phase 0 bursts pulse select high between words
// [RULE12]: mode 3: data with first fall, sample rising
// [RULE13]: command frame opens with 8-bit control, input ignored
// [RULE14]: slave waits one clock, replies 4 to 16 bits
// [RULE15]: command idle: clock low, select high, data low
// [RULE16]: select fall loads control byte, drives its msb
// [RULE17]: select low whole frame, input undriven during control
// [RULE18]: slave latches rising, replies on falling edges
// [RULE19]: reply bits sampled on rising clock edges
// [RULE20]: single frame: select rises, word stored
// [RULE21]: slave releases input after last bit or select
// [RULE22]: burst frames: next control byte follows immediately
// [RULE23]: burst frames: word stored at falling edge
// [RULE24]: as slave, first bit on first rise
// [RULE25]: start only when enabled with data waiting
`timescale 1ns/1ps
module ssi_frame_sequencer
  import ssi_pkg::*;
#(
  parameter int DIV_W = 8
) (
  input wire logic clk, // system clock
  input wire logic rst, // asynchronous reset, active high
  input wire logic clkEn, // freezes all state except the link-clock slave when low
  input wire logic enable, // port enable
  input wire logic isSlave, // slave when high, master when low
  input wire logic cmdRespMode, // command/response format when high
  input wire logic clockPolarity, // idle clock level in spi format
  input wire logic clockPhase, // capture on second edge when high
  input wire logic [SIZE_W-1:0] wordSizeM1, // word length minus one
  input wire logic [DIV_W-1:0] halfPeriodDiv, // clocks per half bit
  input wire logic [WORD_W-1:0] txData, // oldest transmit fifo entry
  input wire logic txValid, // transmit fifo holds a word
  output logic txReady, // pops the transmit fifo
  output logic [WORD_W-1:0] rxData, // received word
  output logic rxValid, // pushes rxData into the receive fifo
  output logic busy, // master frame in progress
  input wire logic serialBitClockIn, // bit clock pad input
  output logic serialBitClockOut, // bit clock pad output
  output logic serialBitClockOe_n, // bit clock pad enable
  input wire logic frameSelectIn, // frame select pad input
  output logic frameSelectOut, // frame select pad output
  output logic frameSelectOe_n, // frame select pad enable
  output logic serialOutLine, // transmit data pad output
  output logic serialOutOe_n, // transmit data pad enable
  input wire logic serialInLine // receive data pad input
);
  logic [SIZE_W-1:0] sizeM1;
  logic cpolEff;
  logic cphaEff;
  logic halfTick;
  logic step;
  logic [SYNC_STAGES-1:0] inSync_reg;
  logic [SYNC_STAGES-1:0] fssSync_reg;
  logic [SYNC_STAGES:0] doneSync_reg;
  seq_state_e state_reg;
  cr_phase_e crPhase_reg;
  logic phaseHalf_reg;
  logic [SIZE_W-1:0] bitCnt_reg;
  logic [WORD_W-1:0] txShift_reg;
  logic [WORD_W-1:0] rxShift_reg;
  logic [SIZE_W-1:0] curLastBit;
  logic [SIZE_W-1:0] loadSizeM1;
  logic [WORD_W-1:0] loadValue;
  logic [WORD_W-1:0] rxMask;
  logic lastBit;
  logic captureOn;
  logic startFrame;
  logic wordDone;
  logic chainNext;
  logic masterLoad;
  logic slaveLoad;
  logic pushMaster;
  logic doneEdge;
  logic slaveEmpty_reg;
  logic [WORD_W-1:0] slaveWord_reg;
  logic txLine_reg;
  logic sclkNext;
  logic txNext;

  ssi_link_if lnk ();

  ssi_half_tick #(
    .DIV_W(DIV_W)
  ) divider (
    .clk(clk),
    .rst(rst),
    .clkEn(clkEn),
    .halfDiv(halfPeriodDiv),
    .tick(halfTick)
  );

  ssi_link_slave slave (
    .rst(rst),
    .linkClock(serialBitClockIn),
    .frameSelect(frameSelectIn),
    .serialIn(serialInLine),
    .lnk(lnk.link)
  );

  // settings are only changed while the port is disabled
  assign lnk.wordSizeM1 = sizeM1;
  assign lnk.cmdResp = cmdRespMode;
  assign lnk.clockPolarity = clockPolarity;
  assign lnk.clockPhase = clockPhase;
  assign lnk.txWord = slaveWord_reg;

  // shorter sizes are raised to the smallest legal word
  assign sizeM1 = (wordSizeM1 < MIN_SIZE_M1) ? MIN_SIZE_M1 : wordSizeM1; // [RULE1]
  // command/response runs with a low idle clock and rising capture
  assign cpolEff = clockPolarity & ~cmdRespMode; // [RULE15]
  assign cphaEff = clockPhase & ~cmdRespMode;
  assign step = clkEn & halfTick;
  assign busy = (state_reg != ST_IDLE);

  always_comb begin
    curLastBit = sizeM1;
    if (cmdRespMode) begin
      case (crPhase_reg)
        CR_CTRL: curLastBit = CTRL_SIZE_M1; // [RULE13]
        CR_WAIT: curLastBit = WAIT_SIZE_M1; // [RULE14]
        default: curLastBit = sizeM1;
      endcase
    end
  end

  assign lastBit = (bitCnt_reg == curLastBit);
  // control bits and the wait bit are not captured
  assign captureOn = ~cmdRespMode | (crPhase_reg == CR_REPLY); // [RULE13] [RULE17]
  assign wordDone = (state_reg == ST_SHIFT) && step && phaseHalf_reg && lastBit
    && (~cmdRespMode || crPhase_reg == CR_REPLY);
  assign chainNext = wordDone && enable && txValid && (cmdRespMode || cphaEff); // [RULE6] [RULE22]
  assign startFrame = (state_reg == ST_IDLE) && step && enable && !isSlave
    && txValid; // [RULE25]
  assign masterLoad = startFrame | chainNext;
  assign pushMaster = (wordDone && chainNext)
    || ((state_reg == ST_TAIL) && step); // [RULE20] [RULE23]

  // left-align the word so the msb leaves first
  assign loadSizeM1 = cmdRespMode ? CTRL_SIZE_M1 : sizeM1;
  assign loadValue = txData << (TOP_BIT - loadSizeM1); // [RULE1] [RULE16]
  assign rxMask = ALL_ONES >> (TOP_BIT - sizeM1);

  // slave words cross over by toggle; the word itself is stable meanwhile
  assign doneEdge = doneSync_reg[SYNC_STAGES] ^ doneSync_reg[SYNC_STAGES-1];
  assign slaveLoad = clkEn && isSlave && enable && txValid
    && (slaveEmpty_reg || doneEdge);
  assign txReady = masterLoad | slaveLoad;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      inSync_reg <= '0;
      fssSync_reg <= '1;
      doneSync_reg <= '0;
    end else if (clkEn) begin
      inSync_reg <= {inSync_reg[SYNC_STAGES-2:0], serialInLine};
      fssSync_reg <= {fssSync_reg[SYNC_STAGES-2:0], frameSelectIn};
      doneSync_reg <= {doneSync_reg[SYNC_STAGES-1:0], lnk.doneToggle};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
    end else if (step) begin
      case (state_reg)
        ST_IDLE: begin
          if (startFrame) begin
            // command frames drive the msb right at the select fall
            state_reg <= cmdRespMode ? ST_SHIFT : ST_START; // [RULE3] [RULE16]
          end
        end
        ST_START: begin
          state_reg <= ST_SHIFT; // [RULE3] [RULE9] [RULE12]
        end
        ST_SHIFT: begin
          if (wordDone && !chainNext) begin
            state_reg <= ST_TAIL; // [RULE5]
          end
        end
        ST_TAIL: begin
          // the idle half that follows is the select pulse between words
          state_reg <= ST_IDLE; // [RULE5] [RULE11]
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phaseHalf_reg <= 1'b0;
      bitCnt_reg <= '0;
      crPhase_reg <= CR_CTRL;
    end else if (step) begin
      if (state_reg != ST_SHIFT) begin
        phaseHalf_reg <= 1'b0;
        bitCnt_reg <= '0;
        crPhase_reg <= CR_CTRL;
      end else if (!phaseHalf_reg) begin
        phaseHalf_reg <= 1'b1;
      end else begin
        phaseHalf_reg <= 1'b0;
        if (!lastBit) begin
          bitCnt_reg <= bitCnt_reg + 1'b1;
        end else begin
          bitCnt_reg <= '0;
          case (crPhase_reg)
            CR_CTRL: crPhase_reg <= cmdRespMode ? CR_WAIT : CR_CTRL; // [RULE14]
            CR_WAIT: crPhase_reg <= CR_REPLY; // [RULE14]
            default: crPhase_reg <= CR_CTRL; // [RULE22]
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txShift_reg <= '0;
    end else if (clkEn) begin
      if (masterLoad) begin
        txShift_reg <= loadValue; // [RULE16] [RULE22]
      end else if (step && state_reg == ST_SHIFT && phaseHalf_reg) begin
        if (!lastBit) begin
          txShift_reg <= {txShift_reg[WORD_W-2:0], 1'b0}; // [RULE4] [RULE10] [RULE12]
        end else begin
          // line stays low through the wait bit and the reply
          txShift_reg <= NO_BITS;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxShift_reg <= '0;
    end else if (step && state_reg == ST_SHIFT && !phaseHalf_reg && captureOn) begin
      rxShift_reg <= {rxShift_reg[WORD_W-2:0], inSync_reg[SYNC_STAGES-1]}; // [RULE19] [RULE4]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxData <= '0;
      rxValid <= 1'b0;
    end else if (clkEn) begin
      rxValid <= 1'b0;
      if (pushMaster) begin
        rxData <= rxShift_reg & rxMask; // [RULE20] [RULE23]
        rxValid <= 1'b1;
      end else if (isSlave && doneEdge) begin
        rxData <= lnk.rxWord & rxMask;
        rxValid <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slaveWord_reg <= '0;
      slaveEmpty_reg <= 1'b1;
    end else if (clkEn) begin
      if (slaveLoad) begin
        slaveWord_reg <= txData;
        slaveEmpty_reg <= 1'b0;
      end else if (doneEdge || !isSlave) begin
        slaveEmpty_reg <= 1'b1;
      end
    end
  end

  // clock level: polarity at rest, toggled in the active half of each bit
  always_comb begin
    sclkNext = cpolEff; // [RULE2] [RULE7] [RULE15]
    if (state_reg == ST_SHIFT) begin
      sclkNext = cpolEff ^ phaseHalf_reg ^ cphaEff; // [RULE2] [RULE3] [RULE12]
    end
  end

  always_comb begin
    txNext = 1'b0; // [RULE7] [RULE15]
    if (state_reg == ST_SHIFT) begin
      txNext = txShift_reg[WORD_W-1]; // [RULE1]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      serialBitClockOut <= 1'b0;
      serialBitClockOe_n <= 1'b1;
      frameSelectOut <= 1'b1;
      frameSelectOe_n <= 1'b1;
      txLine_reg <= 1'b0;
      serialOutOe_n <= 1'b1;
    end else if (clkEn) begin
      serialBitClockOut <= sclkNext;
      serialBitClockOe_n <= isSlave; // [RULE8]
      frameSelectOut <= (state_reg == ST_IDLE); // [RULE5] [RULE11] [RULE17]
      frameSelectOe_n <= isSlave;
      txLine_reg <= txNext;
      serialOutOe_n <= isSlave & fssSync_reg[SYNC_STAGES-1];
    end
  end

  // slave data leaves straight from the link-clock shifter
  assign serialOutLine = isSlave ? lnk.slaveBit : txLine_reg;
endmodule

/* File: logic/ssi_half_tick.sv */
// half bit period tick generator for the master bit clock
`timescale 1ns/1ps
module ssi_half_tick #(
  parameter int DIV_W = 8
) (
  input wire logic clk, // system clock
  input wire logic rst, // asynchronous reset, active high
  input wire logic clkEn, // freezes the counter when low
  input wire logic [DIV_W-1:0] halfDiv, // system clocks per half bit period
  output logic tick // one-cycle pulse per half period
);
  logic [DIV_W-1:0] cnt_reg;
  logic [DIV_W-1:0] lastCnt;

  // zero behaves as one
  assign lastCnt = (halfDiv == '0) ? '0 : halfDiv - 1'b1;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
      tick <= 1'b0;
    end else if (clkEn) begin
      if (cnt_reg >= lastCnt) begin
        cnt_reg <= '0;
        tick <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
        tick <= 1'b0;
      end
    end
  end
endmodule

/* File: logic/ssi_link_slave.sv */
// slave shifter clocked by the bit clock arriving from the master
`timescale 1ns/1ps
module ssi_link_slave
  import ssi_pkg::*;
(
  input wire logic rst, // asynchronous reset, active high
  input wire logic linkClock, // bit clock pin from the master
  input wire logic frameSelect, // frame select pin, active low
  input wire logic serialIn, // data from the master
  ssi_link_if.link lnk // words and settings shared with the core
);
  logic sampleClk;
  logic frameRst;
  logic [SIZE_W-1:0] sampleCnt_reg;
  logic [SIZE_W-1:0] outIdx_reg;
  logic [WORD_W-1:0] shift_reg;
  logic [SIZE_W-1:0] bitSel;

  // sampling edge is rising for modes 0 and 3 and for command/response
  assign sampleClk = linkClock ^ (~lnk.cmdResp & (lnk.clockPolarity ^ lnk.clockPhase));
  // frame select high ends the frame even when the bit clock stands still
  assign frameRst = rst | frameSelect;
  assign bitSel = lnk.wordSizeM1 - outIdx_reg;
  // msb stands on the line as soon as frame select falls
  assign lnk.slaveBit = lnk.txWord[bitSel]; // [RULE1] [RULE9]

  always_ff @(posedge sampleClk or posedge frameRst) begin
    if (frameRst) begin
      sampleCnt_reg <= '0;
      shift_reg <= '0;
    end else begin
      shift_reg <= {shift_reg[WORD_W-2:0], serialIn}; // [RULE24]
      if (sampleCnt_reg == lnk.wordSizeM1) begin
        sampleCnt_reg <= '0;
      end else begin
        sampleCnt_reg <= sampleCnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge sampleClk or posedge rst) begin
    if (rst) begin
      lnk.rxWord <= '0;
      lnk.doneToggle <= 1'b0;
    end else if (sampleCnt_reg == lnk.wordSizeM1) begin
      lnk.rxWord <= {shift_reg[WORD_W-2:0], serialIn};
      lnk.doneToggle <= ~lnk.doneToggle;
    end
  end

  // outgoing bit advances on the edge opposite the sampling edge
  always_ff @(negedge sampleClk or posedge frameRst) begin
    if (frameRst) begin
      outIdx_reg <= '0;
    end else begin
      outIdx_reg <= sampleCnt_reg; // [RULE4] [RULE10] [RULE12]
    end
  end
endmodule

/* File: sim/ssi_frame_sequencer_properties.sv */
// port assertions for the serial frame sequencer
`timescale 1ns/1ps
module ssi_frame_sequencer_properties #(
  parameter int DIV_W = 8
) (
  input wire logic clk, // system clock
  input wire logic rst, // async reset
  input wire logic enable, // port enable
  input wire logic isSlave, // slave role
  input wire logic cmdRespMode, // format
  input wire logic clockPolarity, // idle level
  input wire logic clockPhase, // capture edge
  input wire logic [DIV_W-1:0] halfPeriodDiv, // half bit
  input wire logic txReady, // pop
  input wire logic rxValid, // push
  input wire logic busy, // frame on
  input wire logic serialBitClockOut, // clock pad
  input wire logic serialBitClockOe_n, // clock enable
  input wire logic frameSelectOut, // select pad
  input wire logic frameSelectOe_n, // select enable
  input wire logic serialOutLine // data pad
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [DIV_W:0] sinceEdge;
  logic lastClk;
  // clocks since the bit clock pad last moved
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sinceEdge <= '0;
      lastClk <= 1'b0;
    end else begin
      lastClk <= serialBitClockOut;
      if (serialBitClockOut != lastClk) begin
        sinceEdge <= {{DIV_W{1'b0}}, 1'b1};
      end else if (!(&sinceEdge)) begin
        sinceEdge <= sinceEdge + 1'b1;
      end
    end
  end
  property p_idle_level;
    !isSlave && !busy && !$past(busy) && !$past(busy, 2) && !$past(rst) && !$past(rst, 2)
      && $stable(clockPolarity) && $stable(cmdRespMode) && $stable(isSlave)
      |-> frameSelectOut && !serialOutLine
      && serialBitClockOut == (cmdRespMode ? 1'b0 : clockPolarity);
  endproperty
  a_idle_level: assert property (p_idle_level)
    else $error("idle line levels wrong");
  property p_pad_enables;
    !$past(rst) && $stable(isSlave)
      |-> serialBitClockOe_n == isSlave && frameSelectOe_n == isSlave;
  endproperty
  a_pad_enables: assert property (p_pad_enables)
    else $error("pad enable does not follow role");
  property p_start_gate;
    $fell(frameSelectOut) && !isSlave
      |-> $past(txReady, 2) && $past(enable, 2);
  endproperty
  a_start_gate: assert property (p_start_gate)
    else $error("frame began without a word");
  property p_rx_at_rise;
    $rose(frameSelectOut) && !isSlave |-> $past(rxValid);
  endproperty
  a_rx_at_rise: assert property (p_rx_at_rise)
    else $error("no word stored at select rise");
  property p_select_after_capture;
    $rose(frameSelectOut) && !isSlave |-> sinceEdge ==
      ((clockPhase && !cmdRespMode) ? {halfPeriodDiv, 1'b0} : {1'b0, halfPeriodDiv});
  endproperty
  a_select_after_capture: assert property (p_select_after_capture)
    else $error("select rose at wrong distance from capture");
  property p_burst_low;
    txReady && !frameSelectOut && !isSlave |=> !frameSelectOut [*8];
  endproperty
  a_burst_low: assert property (p_burst_low)
    else $error("select left low burst");
  property p_phase0_pulse;
    txReady && !isSlave && !cmdRespMode && !clockPhase
      |-> frameSelectOut && $past(frameSelectOut, 2);
  endproperty
  a_phase0_pulse: assert property (p_phase0_pulse)
    else $error("no select pulse between words");
  property p_clock_spacing;
    $changed(serialBitClockOut) && !isSlave && !$past(rst) && !$past(rst, 2)
      |-> sinceEdge >= {1'b0, halfPeriodDiv};
  endproperty
  a_clock_spacing: assert property (p_clock_spacing)
    else $error("bit clock moved too soon");
endmodule
bind ssi_frame_sequencer ssi_frame_sequencer_properties #(.DIV_W(DIV_W)) checker_inst (
  .clk, .rst, .enable, .isSlave, .cmdRespMode, .clockPolarity, .clockPhase, .halfPeriodDiv,
  .txReady, .rxValid, .busy, .serialBitClockOut, .serialBitClockOe_n, .frameSelectOut,
  .frameSelectOe_n, .serialOutLine
);

/* File: sim/ssi_frame_sequencer_tb.sv */
// bench driving the frame sequencer against a serial partner
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module ssi_frame_sequencer_tb;
  import ssi_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic clkEn = 1'b1;
  logic enable = 1'b0;
  logic isSlave = 1'b0;
  logic cmdRespMode = 1'b0;
  logic clockPolarity = 1'b0;
  logic clockPhase = 1'b0;
  logic [SIZE_W-1:0] wordSizeM1 = 4'h7;
  logic [7:0] halfPeriodDiv = 8'h04;
  logic [WORD_W-1:0] txData = 16'h0000;
  logic txValid = 1'b0;
  logic sClk = 1'b0;
  logic sFss = 1'b1;
  logic sIn = 1'b0;
  logic [WORD_W-1:0] reply = 16'h0000;
  logic [WORD_W-1:0] rxData, pRx, seenRx;
  logic [7:0] pCtrl;
  logic txReady, rxValid, busy, serialBitClockOut, serialBitClockOe_n, pMiso;
  logic frameSelectOut, frameSelectOe_n, serialOutLine, serialOutOe_n;
  int errors = 0;
  int n_checks = 0;
  int nRx = 0;
  int cyc = 0;
  wire logic serialBitClockIn = serialBitClockOe_n ? sClk : serialBitClockOut;
  wire logic frameSelectIn = frameSelectOe_n ? sFss : frameSelectOut;
  wire logic serialInLine = isSlave ? sIn : pMiso;

  ssi_frame_sequencer #(.DIV_W(8)) ssi_frame_sequencer_inst (
    .clk, .rst, .clkEn, .enable, .isSlave, .cmdRespMode, .clockPolarity, .clockPhase,
    .wordSizeM1, .halfPeriodDiv, .txData, .txValid, .txReady, .rxData, .rxValid, .busy,
    .serialBitClockIn, .serialBitClockOut, .serialBitClockOe_n, .frameSelectIn,
    .frameSelectOut, .frameSelectOe_n, .serialOutLine, .serialOutOe_n, .serialInLine
  );
  ssi_spi_partner ssi_spi_partner_inst (
    .sclk(serialBitClockIn), .fssN(frameSelectIn), .mosi(serialOutLine), .cmdResp(cmdRespMode),
    .pol(clockPolarity), .pha(clockPhase), .lenM1(wordSizeM1), .reply, .miso(pMiso),
    .rxWord(pRx), .ctrlWord(pCtrl)
  );

  always #5 clk = ~clk;
  always @(negedge clk) begin
    if (rxValid === 1'b1) begin
      seenRx = rxData;
      nRx++;
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // master run: mode is {cmdResp, polarity, phase}, n words back to back
  task automatic run(input logic [2:0] mode, input logic [3:0] lm, input int n);
    int sent;
    int got;
    logic pop;
    logic [WORD_W-1:0] m;
    m = ALL_ONES >> (TOP_BIT - lm);
    {cmdRespMode, clockPolarity, clockPhase} = mode;
    wordSizeM1 = lm;
    reply = 16'h9C6B ^ {12'h000, lm};
    sent = 0;
    got = 0;
    txData = 16'hC3A5;
    txValid = 1'b1;
    enable = 1'b1;
    for (int c = 0; c < 3000 && got < n; c++) begin
      @(negedge clk);
      pop = txReady;
      if (rxValid === 1'b1) begin
        got++;
        `CHK("rxData", reply & m, rxData)
      end
      @(posedge clk);
      #1;
      if (pop === 1'b1) begin
        sent++;
        txData = txData + 16'h1357;
        txValid = (sent < n);
      end
    end
    for (int c = 0; c < 200 && busy !== 1'b0; c++) @(posedge clk);
    repeat (12) @(posedge clk);
    #1;
    enable = 1'b0;
    @(posedge clk);
    #1;
    `CHK("words", n, got)
    `CHK("clkOe", 1'b0, serialBitClockOe_n)
    if (mode[2]) `CHK("ctrl", txData[7:0] - 8'h57, pCtrl)
    else `CHK("txWord", (txData - 16'h1357) & m, pRx & m)
    $display("run mode %b len %0d done", mode, lm + 1);
  endtask

  task automatic idle_check();
    int pops;
    pops = 0;
    txValid = 1'b1;
    repeat (60) begin
      @(negedge clk);
      if (txReady !== 1'b0) pops++;
    end
    `CHK("pops", 0, pops)
    `CHK("fss", 1'b1, frameSelectOut)
    @(posedge clk);
    #1;
    clkEn = 1'b0;
    enable = 1'b1;
    repeat (40) begin
      @(negedge clk);
      if (txReady !== 1'b0) pops++;
    end
    `CHK("frozenPops", 0, pops)
    @(posedge clk);
    #1;
    clkEn = 1'b1;
    enable = 1'b0;
    txValid = 1'b0;
    @(posedge clk);
    #1;
    $display("disabled check done");
  endtask

  // bench acts as master on a 32 ns link clock, still outside the frame
  task automatic slave_frame(input logic [2:0] mode, input logic [7:0] w);
    int n0;
    logic [7:0] so;
    so = 8'h00;
    isSlave = 1'b1;
    {cmdRespMode, clockPolarity, clockPhase} = mode;
    wordSizeM1 = 4'h7;
    sClk = mode[1];
    @(posedge clk);
    #1;
    enable = 1'b1;
    txData = {8'h00, ~w};
    txValid = 1'b1;
    n0 = nRx;
    @(posedge clk);
    #1;
    txValid = 1'b0;
    #22 sFss = 1'b0;
    // data set on the change edge, slave output read just before the sampling edge
    for (int i = 7; i >= 0; i--) begin
      if (!mode[0]) sIn = w[i];
      #16;
      if (!mode[0]) so = {so[6:0], serialOutLine};
      sClk = ~sClk;
      if (mode[0]) sIn = w[i];
      #16;
      if (mode[0]) so = {so[6:0], serialOutLine};
      sClk = ~sClk;
    end
    `CHK("slaveOe", 1'b0, serialOutOe_n)
    `CHK("slaveTx", ~w, so)
    #16 sFss = 1'b1;
    sIn = ~sIn;
    repeat (20) @(posedge clk);
    #1;
    `CHK("slaveWords", n0 + 1, nRx)
    `CHK("slaveRx", {8'h00, w}, seenRx)
    `CHK("slaveClkOe", 1'b1, serialBitClockOe_n)
    enable = 1'b0;
    $display("slave frame done");
  endtask

  initial begin
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    idle_check();
    run(3'b001, 4'hF, 1);
    run(3'b001, 4'h3, 3);
    run(3'b010, 4'h7, 2);
    run(3'b011, 4'h4, 3);
    run(3'b000, 4'h3, 2);
    run(3'b100, 4'h3, 1);
    run(3'b100, 4'hF, 3);
    slave_frame(3'b000, 8'hB4);
    slave_frame(3'b011, 8'h5A);
    finish_test();
  end
endmodule

/* File: sim/ssi_spi_partner.sv */
// behavioural off-chip serial device facing the sequencer
`timescale 1ns/1ps
module ssi_spi_partner
  import ssi_pkg::*;
(
  input wire logic sclk, // bit clock wire
  input wire logic fssN, // select, active low
  input wire logic mosi, // data from the port
  input wire logic cmdResp, // command/response
  input wire logic pol, // idle clock level
  input wire logic pha, // second edge capture
  input wire logic [SIZE_W-1:0] lenM1, // bits minus one
  input wire logic [WORD_W-1:0] reply, // word sent back
  output logic miso, // data to the port
  output logic [WORD_W-1:0] rxWord, // bits captured
  output logic [7:0] ctrlWord // control byte seen
);
  int nS = 0;
  int q = 0;
  int txIdx = 0;
  initial begin
    miso = 1'b0;
    rxWord = 16'h0000;
    ctrlWord = 8'h00;
  end
  always @(negedge fssN) begin
    nS = 0;
    txIdx = 0;
    if (!cmdResp && !pha) begin
      miso = reply[lenM1];
      txIdx = 1;
    end
  end
  // released line shows the inverse of its last level
  always @(posedge fssN) miso = ~miso;
  always @(sclk) begin
    if (fssN === 1'b0) begin
      if (sclk === (cmdResp | ~(pol ^ pha))) begin
        q = nS % (int'(lenM1) + 10);
        nS++;
        rxWord = {rxWord[WORD_W-2:0], mosi};
        if (cmdResp && q < 8) ctrlWord = {ctrlWord[6:0], mosi};
      end else if (cmdResp) begin
        q = (nS - 1) % (int'(lenM1) + 10);
        // one wait bit after the control byte, then the reply
        if (q >= 8 && q <= 8 + int'(lenM1)) miso = reply[int'(lenM1) + 8 - q];
        else miso = ~miso;
      end else begin
        miso = reply[int'(lenM1) - txIdx % (int'(lenM1) + 1)];
        txIdx++;
      end
    end
  end
endmodule
